/* rtl/l2_config_status_regs.sv */
// coprocessor register bank: cluster options, l2 extended control, base
`timescale 1ns/10ps
`include "l2_config_status_cfg.svh"

module l2_config_status_regs #(
    parameter logic [1:0] CPUS_M1 = `DEF_CPUS_M1,
    parameter logic IRQ_CTRL = `DEF_IRQ_CTRL,
    parameter logic RAM_LAT = `DEF_RAM_LAT
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire l2_config_status_pkg::cp_req_type cp_req,
    output l2_config_status_pkg::cp_resp_type cp_resp,
    input wire logic nonsecure_error_access_grant,
    input wire logic async_bus_error,
    input wire logic [39:0] peripheral_base_input,
    output logic async_error_flag
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    // compare a request's coprocessor fields with one encoding
    function automatic logic enc_hit(
        input l2_config_status_pkg::cp_req_type req,
        input logic [13:0] enc
    );
        enc_hit = ({req.opc1, req.crn, req.crm, req.opc2} == enc);
    endfunction : enc_hit

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    l2_config_status_pkg::cp_resp_type resp_reg;
    l2_config_status_pkg::cp_resp_type resp_next;
    l2_config_status_pkg::strap_state_type strap_reg;
    l2_config_status_pkg::strap_state_type strap_next;
    logic async_err_reg;
    logic async_err_next;
    logic [24:0] base_reg;
    logic [24:0] base_next;

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    wire logic take = clk_en & cp_req.valid;
    wire logic privileged = (cp_req.priv != 2'h0);
    wire logic hit_opt = enc_hit(cp_req, `ENC_CLUSTER_OPTIONS);
    wire logic hit_ect = enc_hit(cp_req, `ENC_L2_EXT_CONTROL);
    wire logic hit_base = enc_hit(cp_req, `ENC_PERIPH_BASE);
    wire logic hit_fast_context_switch_ext = enc_hit(cp_req, `ENC_FAST_CTX_SWITCH);
    wire logic hit_aux = enc_hit(cp_req, `ENC_AUX_ATTR_0) |
        enc_hit(cp_req, `ENC_AUX_ATTR_1) |
        enc_hit(cp_req, `ENC_HYP_AUX_ATTR_0) |
        enc_hit(cp_req, `ENC_HYP_AUX_ATTR_1);
    wire logic hit_any = hit_opt | hit_ect | hit_base | hit_fast_context_switch_ext | hit_aux;

    // writes to read-only registers are refused like unmapped ones
    wire logic ro_write = cp_req.write & (hit_opt | hit_base);
    // everything here needs privilege level 1 or above
    wire logic refuse = ~privileged | ~hit_any | ro_write;

    // write rights on the control register depend on security state
    wire logic ect_wr_ok = ~cp_req.nonsecure |
        nonsecure_error_access_grant;
    wire logic ect_write = take & cp_req.write & hit_ect & ~refuse &
        ect_wr_ok;
    // only a written zero clears; only bit 29 is ever stored
    wire logic err_clear = ect_write &
        ~cp_req.wdata[`ECT_ASYNC_ERR_BIT];

    // ---------------------------------------------------------------
    // read values
    // ---------------------------------------------------------------

    // build options are constants; reserved bits read zero
    wire logic [31:0] opt_value = {6'h00, CPUS_M1, IRQ_CTRL, 22'h00_0000,
        RAM_LAT};
    wire logic [31:0] ect_value = {2'h0, async_err_reg,
        29'h0000_0000};
    wire logic [31:0] base_value = {base_reg[24:8], 7'h00,
        base_reg[7:0]};

    // unknown-reading registers return zero, writes dropped
    wire logic [31:0] read_mux =
        hit_opt ? opt_value :
        hit_ect ? ect_value :
        hit_base ? base_value :
        32'h0000_0000;

    // ---------------------------------------------------------------
    // next values
    // ---------------------------------------------------------------

    // answer every taken request on the next edge
    always_comb
    begin
        resp_next.ack = take;
        resp_next.undef = take & refuse;
        resp_next.rdata = (take & ~refuse & ~cp_req.write) ?
            read_mux : `RDATA_RESET;
    end

    // a bus error in the clearing cycle keeps the flag set
    assign async_err_next = async_bus_error |
        (async_err_reg & ~err_clear);

    // base captured once after reset, then frozen
    always_comb
    begin
        strap_next = strap_reg;
        base_next = base_reg;
        case (strap_reg)
            l2_config_status_pkg::ST_LOAD:
            begin
                base_next = {
                    peripheral_base_input[`PB_HIGH_HI:`PB_HIGH_LO],
                    peripheral_base_input[`PB_IN_UPPER_HI:`PB_IN_UPPER_LO]
                };
                strap_next = l2_config_status_pkg::ST_RUN;
            end
            l2_config_status_pkg::ST_RUN:
            begin
                strap_next = l2_config_status_pkg::ST_RUN;
            end
            default:
            begin
                strap_next = l2_config_status_pkg::ST_LOAD;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------

    // answer register; clk_en low freezes it, ack included
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            resp_reg <= '0;
        else if (clk_en)
            resp_reg <= resp_next;
    end

    // sticky error flag
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            async_err_reg <= `ASYNC_ERR_RESET;
        else if (clk_en)
            async_err_reg <= async_err_next;
    end

    // strap capture: reset loads constants, the pin is read afterwards
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            strap_reg <= l2_config_status_pkg::ST_LOAD;
            base_reg <= 25'h000_0000;
        end
        else if (clk_en)
        begin
            strap_reg <= strap_next;
            base_reg <= base_next;
        end
    end

    assign cp_resp = resp_reg;
    assign async_error_flag = async_err_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking chk_cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    wire logic [31:0] base_expect = {peripheral_base_input[31:15],
        7'h00, peripheral_base_input[39:32]};

    answer_next_a: assert property (
        take |=> cp_resp.ack)
        else $error("request not answered next cycle");

    unpriv_refused_a: assert property (
        take & ~privileged |=> cp_resp.undef && cp_resp.rdata == 32'h0)
        else $error("unprivileged access not refused");

    options_read_a: assert property (
        take & hit_opt & privileged & ~cp_req.write
        |=> cp_resp.rdata == {6'h00, CPUS_M1, IRQ_CTRL, 22'h0, RAM_LAT})
        else $error("options register value wrong");

    error_set_a: assert property (
        clk_en & async_bus_error |=> async_error_flag)
        else $error("bus error did not set flag");

    error_sticky_a: assert property (
        clk_en & async_error_flag & ~err_clear |=> async_error_flag)
        else $error("error flag dropped without clear");

    ns_write_ignored_a: assert property (
        take & cp_req.write & hit_ect & cp_req.nonsecure &
        ~nonsecure_error_access_grant & ~async_bus_error
        |=> $stable(async_error_flag))
        else $error("nonsecure write took effect without grant");

    clear_zero_a: assert property (
        err_clear & ~async_bus_error |=> ~async_error_flag)
        else $error("write of zero did not clear flag");

    write_one_keeps_a: assert property (
        take & cp_req.write & hit_ect & async_error_flag &
        cp_req.wdata[`ECT_ASYNC_ERR_BIT] |=> async_error_flag)
        else $error("write of one changed flag");

    context_raz_a: assert property (
        take & hit_fast_context_switch_ext & privileged & ~cp_req.write
        |=> cp_resp.rdata == 32'h0 && !cp_resp.undef)
        else $error("context switch register not zero");

    base_capture_a: assert property (
        clk_en && strap_reg == l2_config_status_pkg::ST_LOAD
        |=> base_value == $past(base_expect))
        else $error("base not captured from input");

    base_frozen_a: assert property (
        strap_reg == l2_config_status_pkg::ST_RUN |=> $stable(base_reg))
        else $error("base register changed after capture");

    ro_write_refused_a: assert property (
        take & ro_write & privileged
        |=> cp_resp.undef && cp_resp.rdata == 32'h0000_0000)
        else $error("write to read-only register not refused");

    unmapped_refused_a: assert property (
        take & ~hit_any
        |=> cp_resp.undef)
        else $error("unmapped encoding not refused");

    base_read_a: assert property (
        take & hit_base & privileged & ~cp_req.write
        |=> cp_resp.rdata == $past(base_value) && !cp_resp.undef)
        else $error("base register read wrong");

    control_read_a: assert property (
        take & hit_ect & privileged & ~cp_req.write
        |=> cp_resp.rdata == {2'h0, $past(async_error_flag), 29'h0000_0000})
        else $error("control register read wrong");

    write_rdata_zero_a: assert property (
        take & cp_req.write
        |=> cp_resp.rdata == 32'h0000_0000)
        else $error("write answered with nonzero data");

    ack_pulse_a: assert property (
        clk_en & ~cp_req.valid
        |=> ~cp_resp.ack)
        else $error("answer without a request");

    enable_freeze_a: assert property (
        ~clk_en
        |=> $stable(cp_resp) && $stable(async_error_flag))
        else $error("state moved with clock enable low");

    aux_raz_a: assert property (
        take & hit_aux & privileged
        |=> cp_resp.rdata == 32'h0000_0000 && !cp_resp.undef)
        else $error("attribute indirection register not zero");

    ns_grant_clear_a: assert property (
        take & cp_req.write & hit_ect & cp_req.nonsecure & privileged &
        nonsecure_error_access_grant & ~cp_req.wdata[`ECT_ASYNC_ERR_BIT] &
        ~async_bus_error |=> ~async_error_flag)
        else $error("granted nonsecure clear had no effect");

    clear_cover: cover property (
        async_error_flag ##1 err_clear ##1 ~async_error_flag);
    ns_grant_cover: cover property (
        ect_write & cp_req.nonsecure);
    set_on_clear_cover: cover property (
        err_clear & async_bus_error);
    base_read_cover: cover property (
        take & hit_base & privileged & ~cp_req.write);
    ro_refuse_cover: cover property (
        take & ro_write & privileged);

endmodule : l2_config_status_regs

/* rtl/l2_config_status_cfg.svh */
// encodings, field positions and reset values of the l2 register bank
`ifndef L2_CONFIG_STATUS_CFG_SVH
`define L2_CONFIG_STATUS_CFG_SVH

// ---------------------------------------------------------------
// coprocessor encodings {opc1, crn, crm, opc2}
// ---------------------------------------------------------------
`define ENC_CLUSTER_OPTIONS 14'h0C82
`define ENC_L2_EXT_CONTROL 14'h0C83
`define ENC_PERIPH_BASE 14'h2780
`define ENC_FAST_CTX_SWITCH 14'h0680
`define ENC_AUX_ATTR_0 14'h0518
`define ENC_AUX_ATTR_1 14'h0519
`define ENC_HYP_AUX_ATTR_0 14'h2518
`define ENC_HYP_AUX_ATTR_1 14'h2519

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define OPT_CPUS_HI 25
`define OPT_CPUS_LO 24
`define OPT_IRQ_CTRL_BIT 23
`define OPT_RAM_LAT_BIT 0
`define ECT_ASYNC_ERR_BIT 29
`define PB_HIGH_HI 31
`define PB_HIGH_LO 15
`define PB_UPPER_HI 7
`define PB_UPPER_LO 0
`define PB_IN_UPPER_HI 39
`define PB_IN_UPPER_LO 32

// ---------------------------------------------------------------
// reset values and build defaults
// ---------------------------------------------------------------
`define ASYNC_ERR_RESET 1'b0
`define RDATA_RESET 32'h0000_0000
`define DEF_CPUS_M1 2'h3
`define DEF_IRQ_CTRL 1'h1
`define DEF_RAM_LAT 1'h0

`endif

/* rtl/l2_config_status_pkg.sv */
// types shared by the l2 configuration and status register bank
package l2_config_status_pkg;

    // coprocessor move request, taken in one cycle
    typedef struct packed {
        logic valid;
        logic write;
        logic nonsecure;
        logic [1:0] priv;
        logic [2:0] opc1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] opc2;
        logic [31:0] wdata;
    } cp_req_type;

    // answer, one cycle after the request
    typedef struct packed {
        logic ack;
        logic undef;
        logic [31:0] rdata;
    } cp_resp_type;

    // base address capture sequence
    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN = 2'b10
    } strap_state_type;

endpackage : l2_config_status_pkg

/* testbench/tb_l2_config_status_regs.sv */
// self-checking bench for the l2 configuration and status register bank
`timescale 1ns/10ps

module tb_l2_config_status_regs;

// ---------------------------------------------------------------
// stimulus signals and design
// ---------------------------------------------------------------
logic ref_clk = 1'b0;
logic reset = 1'b1;
logic clk_en = 1'b1;
l2_config_status_pkg::cp_req_type cp_req = '0;
l2_config_status_pkg::cp_resp_type cp_resp;
logic nonsecure_error_access_grant = 1'b0;
logic async_bus_error = 1'b0;
logic [39:0] peripheral_base_input = 40'hA5_DEAD_BEEF;
logic async_error_flag;
logic [13:0] unimpl [5];
int mismatches = 0;
int comparisons = 0;

// 40 MHz clock
always #12.5 ref_clk = ~ref_clk;

// odd build options, so a hardwired default would show
l2_config_status_regs #(
    .CPUS_M1(2'h1),
    .IRQ_CTRL(1'h0),
    .RAM_LAT(1'h1)
) i_l2_config_status_regs (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .cp_req(cp_req),
    .cp_resp(cp_resp),
    .nonsecure_error_access_grant(nonsecure_error_access_grant),
    .async_bus_error(async_bus_error),
    .peripheral_base_input(peripheral_base_input),
    .async_error_flag(async_error_flag)
);

// ---------------------------------------------------------------
// compare, access and closing tasks
// ---------------------------------------------------------------
task automatic chk32(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
        mismatches++;
        $display("mismatch %s expected %h seen %h", name, exp, got);
    end
endtask : chk32

task automatic chk1(input string name, input logic exp, input logic got);
    chk32(name, {31'h0, exp}, {31'h0, got});
endtask : chk1

// one move, answer checked one edge later; e raises a bus error with it
task automatic access(input logic w, input logic ns, input logic [1:0] pv,
                      input logic [13:0] enc, input logic [31:0] wd,
                      input logic un, input logic [31:0] rd,
                      input logic e);
    @(posedge ref_clk);
    cp_req <= l2_config_status_pkg::cp_req_type'({1'b1, w, ns, pv,
                                                  enc, wd});
    async_bus_error <= e;
    @(posedge ref_clk);
    cp_req.valid <= 1'b0;
    async_bus_error <= 1'b0;
    #1;
    chk1("ack", 1'b1, cp_resp.ack);
    chk1("undef", un, cp_resp.undef);
    chk32("rdata", rd, cp_resp.rdata);
endtask : access

task automatic err_pulse();
    @(posedge ref_clk);
    async_bus_error <= 1'b1;
    @(posedge ref_clk);
    async_bus_error <= 1'b0;
    #1;
    chk1("flag set", 1'b1, async_error_flag);
    chk1("ack idle", 1'b0, cp_resp.ack);
endtask : err_pulse

task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask : results

// ---------------------------------------------------------------
// test sequence
// ---------------------------------------------------------------
// encodings as {opc1, crn, crm, opc2}
localparam logic [13:0] OPT = {3'd1, 4'd9, 4'd0, 3'd2};
localparam logic [13:0] ECT = {3'd1, 4'd9, 4'd0, 3'd3};
localparam logic [13:0] PB = {3'd4, 4'd15, 4'd0, 3'd0};

initial
begin
    unimpl = '{{3'd0, 4'd13, 4'd0, 3'd0}, {3'd0, 4'd10, 4'd3, 3'd0},
               {3'd0, 4'd10, 4'd3, 3'd1}, {3'd4, 4'd10, 4'd3, 3'd0},
               {3'd4, 4'd10, 4'd3, 3'd1}};
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk1("ack at reset", 1'b0, cp_resp.ack);
    chk1("flag at reset", 1'b0, async_error_flag);
    access(0, 0, 1, OPT, 0, 0, 32'h0100_0001, 0);
    access(0, 1, 2, OPT, 0, 0, 32'h0100_0001, 0);
    access(0, 0, 0, OPT, 0, 1, 0, 0);
    access(1, 0, 1, OPT, 32'hFFFF_FFFF, 1, 0, 0);
    access(0, 0, 1, OPT, 0, 0, 32'h0100_0001, 0);
    // held answer while the clock enable is low
    @(posedge ref_clk);
    cp_req.valid <= 1'b1;
    @(posedge ref_clk);
    cp_req.valid <= 1'b0;
    clk_en <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk32("held rdata", 32'h0100_0001, cp_resp.rdata);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    access(0, 1, 1, PB, 0, 0, 32'hDEAD_80A5, 0);
    @(posedge ref_clk);
    peripheral_base_input <= 40'h00_0000_0000;
    access(1, 0, 1, PB, 32'hFFFF_FFFF, 1, 0, 0);
    access(0, 0, 1, PB, 0, 0, 32'hDEAD_80A5, 0);
    access(0, 0, 0, PB, 0, 1, 0, 0);
    access(0, 0, 1, {3'd1, 4'd9, 4'd0, 3'd5}, 0, 1, 0, 0);
    err_pulse();
    access(0, 0, 1, ECT, 0, 0, 32'h2000_0000, 0);
    access(1, 0, 1, ECT, 32'h2000_0000, 0, 0, 0);
    access(1, 1, 1, ECT, 0, 0, 0, 0);
    access(0, 1, 1, ECT, 0, 0, 32'h2000_0000, 0);
    @(posedge ref_clk);
    nonsecure_error_access_grant <= 1'b1;
    access(1, 1, 2, ECT, 32'hFFFF_FFFF, 0, 0, 0);
    access(0, 1, 2, ECT, 0, 0, 32'h2000_0000, 0);
    access(1, 1, 2, ECT, 32'hDFFF_FFFF, 0, 0, 0);
    access(0, 1, 1, ECT, 0, 0, 0, 0);
    @(posedge ref_clk);
    nonsecure_error_access_grant <= 1'b0;
    err_pulse();
    access(0, 0, 0, ECT, 0, 1, 0, 0);
    access(1, 0, 1, ECT, 32'hDFFF_FFFF, 0, 0, 0);
    chk1("flag cleared", 1'b0, async_error_flag);
    access(1, 0, 1, ECT, 0, 0, 0, 1);
    chk1("set beats clear", 1'b1, async_error_flag);
    // unimplemented registers: writes leave no trace
    for (int i = 0; i < 5; i++)
    begin
        access(1, 0, 1, unimpl[i], 32'hFFFF_FFFF, 0, 0, 0);
        access(0, 0, 1, unimpl[i], 0, 0, 0, 0);
    end
    // second reset in mid-run drops the flag
    @(posedge ref_clk);
    reset <= 1'b1;
    peripheral_base_input <= 40'h3C_1234_5678;
    @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    chk1("flag after reset", 1'b0, async_error_flag);
    // base recaptured from the new strap value after the second reset
    access(0, 0, 1, PB, 0, 0, 32'h1234_003C, 0);
    results();
end

// watchdog, well beyond the roughly 80 cycles of the sequence
initial
begin
    #(25 * 3000);
    mismatches++;
    results();
end

endmodule : tb_l2_config_status_regs
